// ### pfi_pkg.sv
// Shared constants and types for the pipeline freeze interlock.
package pfi_pkg;
    // Byte offsets of the registers on the peripheral bus.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_STALLS = 8'h10;
    // Reset values of the writable registers.
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [1:0] RST_MASK = 2'h0;
    // Control bit that lets software hold issue.
    localparam int CTRL_HOLD = 0;
    // Interrupt status bits.
    localparam int IRQ_FREEZE = 0;
    localparam int IRQ_TRAP = 1;
    // Status register field positions.
    localparam int ST_STATE_LSB = 0;
    localparam int ST_PFLD_LSB = 4;
    localparam int ST_STORE_LSB = 8;
    localparam int ST_ADDR_LSB = 12;
    // Occupancy limits of the load, store and address pipes.
    localparam logic [2:0] PFLD_LIMIT = 3'h3;
    localparam logic [2:0] STORE_LIMIT = 3'h2;
    localparam logic [2:0] ADDR_LIMIT = 3'h1;
    // Fixed freeze lengths in clocks.
    localparam logic [4:0] DLY_ONE = 5'h01;
    localparam logic [4:0] DLY_TWO = 5'h02;
    // Fault bit positions in the trait record.
    localparam int FLT_INSTR = 0;
    localparam int FLT_SRC = 1;
    localparam int FLT_RES = 2;
    localparam int FLT_DATA = 3;
    localparam int FLT_ACCESS = 4;

    // Instruction classes as seen by the interlock.
    typedef enum logic [4:0] {
        OP_ADDSUB = 5'b00000, OP_LOGIC = 5'b00001, OP_SHIFT = 5'b00010,
        OP_BR = 5'b00011, OP_BRI = 5'b00100, OP_CALL = 5'b00101,
        OP_CALLI = 5'b00110, OP_BLA = 5'b00111, OP_BCT = 5'b01000,
        OP_BC = 5'b01001, OP_BTE = 5'b01010, OP_TRAP = 5'b01011,
        OP_LD = 5'b01100, OP_ST = 5'b01101, OP_FLD = 5'b01110,
        OP_PFLD = 5'b01111, OP_FST = 5'b10000, OP_FLUSH = 5'b10001,
        OP_FADD = 5'b10010, OP_FMUL = 5'b10011, OP_PFADD = 5'b10100,
        OP_PFMUL = 5'b10101, OP_PFCMP = 5'b10110, OP_PFDUAL = 5'b10111,
        OP_GRAPH = 5'b11000, OP_PGRAPH = 5'b11001, OP_FMOV = 5'b11010,
        OP_OTHER = 5'b11011
    } pfi_op_t;

    // Execution unit of an instruction.
    typedef enum logic [2:0] {
        UNIT_CORE = 3'b000, UNIT_ADDER = 3'b001, UNIT_MUL = 3'b010,
        UNIT_DUAL = 3'b011, UNIT_GRAPH = 3'b100
    } pfi_unit_t;

    // Freeze sequencer states.
    typedef enum logic [1:0] {
        ST_RUN = 2'b00, ST_WAIT = 2'b01, ST_COUNT = 2'b10
    } pfi_state_t;

    // Decoded instruction offered for issue.
    typedef struct packed {
        logic valid;
        pfi_op_t op;
        logic [4:0] dest;
        logic [4:0] src1;
        logic [4:0] src2;
        logic taken;
        logic dcHit;
        logic modified;
    } pfi_inst_t;

    // Traits of the issued instruction.
    typedef struct packed {
        pfi_unit_t unit;
        logic pipelined;
        logic delayed;
        logic setsFlag;
        logic [4:0] faults;
    } pfi_trait_t;
endpackage

// ### pfi_pending.sv
// Occupancy counter for one pipe of outstanding memory work.
`timescale 1ns/1ps
`default_nettype none
module pfi_pending (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inc,
    input wire logic dec,
    output logic [2:0] count
);
    // Counts up on entry and down on completion, saturating at both ends.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 3'h0;
        end else if (inc && !dec && count != 3'h7) begin
            count <= count + 3'h1;
        end else if (dec && !inc && count != 3'h0) begin
            count <= count - 3'h1;
        end
    end
endmodule
`default_nettype wire

// ### pfi_interlock.sv
// Issue interlock and freeze sequencer with trait decode and a bus slave.
//
// Behaviour
// - One clock per instruction unless frozen.
// - Misses add up; other freezes take longest.
// - Fourth pipelined load waits oldest return plus one.
// - Pipelined load hit: two plus outstanding drain.
// - Full store pipe waits next ready plus one.
// - Full address pipe holds loads and stores.
// - Load after store hit stalls one clock.
// - Branch mispredict by delay kind costs one.
// - Graphics result other than OP_FMOV into adder/multiplier stalls one.
// - Graphics result into graphics stalls one.
// - Store then overwriting pipelined op stalls one.
// - Hardware inserts waits whatever the ordering.
// - Only listed instructions update condition flag.
// - Listed transfers execute one delay slot.
// - Fault classes reported per instruction kind.
`timescale 1ns/1ps
`default_nettype none
module pfi_interlock (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pfi_pkg::pfi_inst_t inst,
    input wire logic pfldReturn,
    input wire logic addrIssued,
    input wire logic readyN,
    input wire logic missInst,
    input wire logic [3:0] missInstClocks,
    input wire logic missData,
    input wire logic [3:0] missDataClocks,
    output logic issueAccept,
    output logic freeze,
    output pfi_pkg::pfi_trait_t stageTrait,
    output logic flagUpdate,
    output logic irq
);
    import pfi_pkg::*;

    pfi_state_t state; // Freeze sequencer state.
    logic [4:0] cnt; // Remaining frozen clocks.
    logic served; // Current instruction already paid its freeze.
    logic [1:0] readySync; // Transfer-ready pin synchroniser.
    logic writeAck; // A write beat was accepted on the bus.
    logic [2:0] pfldCnt, storeCnt, addrCnt; // Pipe occupancies.
    logic [4:0] prevDest; // Destination of the last issued instruction.
    logic [4:0] prevFreg; // First source register of the last issued instruction.
    logic prevGraph, prevGraphMove, prevStoreHit, prevFst; // History.
    logic waitPfld, waitDrain, waitStore, waitAddr, readySeen; // Latched waits.
    logic [4:0] post; // Freeze length after any wait.
    logic [4:0] fix, missSum; // Fixed and summed miss delays.
    logic w3, w4, w5, w6, waitAny, evClear, hazardNow; // Hazard terms.
    logic srcMatch, isMem, isLoad, isAluFp, isGraph, isPipeFp; // Class terms.
    logic [31:0] ctrl; // Control register.
    logic [1:0] irqStat, irqMask; // Sticky events and their mask.
    logic [15:0] stalls; // Frozen clocks with a valid instruction offered since last clear.
    logic [1:0] events; // Events raised this cycle.
    logic wrEn; // Bus write in its access phase.
    pfi_trait_t curTrait; // Traits of the offered instruction.

    // Maps an instruction class to its unit, delay, flag and fault traits.
    function automatic pfi_trait_t traitOf(input pfi_op_t op);
        pfi_trait_t t;
        t = '0;
        t.unit = UNIT_CORE;
        t.faults[FLT_ACCESS] = 1'b1;
        unique case (op)
            OP_ADDSUB, OP_LOGIC: t.setsFlag = 1'b1;
            OP_BR, OP_BRI, OP_CALL, OP_CALLI, OP_BLA, OP_BCT: t.delayed = 1'b1;
            OP_TRAP: t.faults[FLT_INSTR] = 1'b1;
            OP_LD, OP_ST, OP_FLD, OP_FST: t.faults[FLT_DATA] = 1'b1;
            OP_PFLD: t.pipelined = 1'b1;
            OP_FADD: begin
                t.unit = UNIT_ADDER;
                t.faults[FLT_SRC] = 1'b1;
                t.faults[FLT_RES] = 1'b1;
            end
            OP_FMUL: begin
                t.unit = UNIT_MUL;
                t.faults[FLT_SRC] = 1'b1;
                t.faults[FLT_RES] = 1'b1;
            end
            OP_PFADD: begin
                t.unit = UNIT_ADDER;
                t.pipelined = 1'b1;
                t.faults[FLT_SRC] = 1'b1;
                t.faults[FLT_RES] = 1'b1;
            end
            OP_PFMUL, OP_PFDUAL: begin
                t.unit = (op == OP_PFMUL) ? UNIT_MUL : UNIT_DUAL;
                t.pipelined = 1'b1;
                t.faults[FLT_SRC] = 1'b1;
                t.faults[FLT_RES] = 1'b1;
            end
            OP_PFCMP: begin
                t.unit = UNIT_ADDER;
                t.pipelined = 1'b1;
                t.setsFlag = 1'b1;
                t.faults[FLT_SRC] = 1'b1;
            end
            OP_GRAPH, OP_FMOV: t.unit = UNIT_GRAPH;
            OP_PGRAPH: begin
                t.unit = UNIT_GRAPH;
                t.pipelined = 1'b1;
            end
            OP_SHIFT, OP_BC, OP_BTE, OP_FLUSH, OP_OTHER: t.faults[FLT_ACCESS] = 1'b1;
            default: t.faults[FLT_ACCESS] = 1'b1;
        endcase
        return t;
    endfunction

    // Classifies the offered instruction for the hazard checks.
    always_comb begin
        curTrait = traitOf(inst.op);
        isLoad = inst.op == OP_LD || inst.op == OP_FLD || inst.op == OP_PFLD;
        isMem = isLoad || inst.op == OP_ST || inst.op == OP_FST;
        isAluFp = curTrait.unit inside {UNIT_ADDER, UNIT_MUL, UNIT_DUAL};
        isGraph = curTrait.unit == UNIT_GRAPH;
        isPipeFp = curTrait.pipelined && inst.op != OP_PFLD;
        srcMatch = inst.src1 == prevDest || inst.src2 == prevDest;
    end

    // hardware-inserted waits
    // Sums the fixed freezes by taking the longest, and the misses by adding.
    always_comb begin
        fix = 5'h00;
        if ((inst.op == OP_BCT && !inst.taken) ||
            ((inst.op == OP_BC || inst.op == OP_BTE) && inst.taken)) begin
            fix = DLY_ONE;
        end
        if ((inst.op == OP_LD || inst.op == OP_FLD) && prevStoreHit) begin
            fix = DLY_ONE;
        end
        if (prevGraph && !prevGraphMove && isAluFp && srcMatch) begin
            fix = DLY_ONE;
        end
        if (prevGraph && isGraph && srcMatch) begin
            fix = DLY_ONE;
        end
        if (prevFst && isPipeFp && inst.dest == prevFreg) begin
            fix = DLY_ONE;
        end
        w3 = inst.op == OP_PFLD && pfldCnt >= PFLD_LIMIT;
        w4 = inst.op == OP_PFLD && inst.dcHit && pfldCnt < PFLD_LIMIT;
        if (w4) begin
            fix = DLY_TWO;
        end
        if (w3 && fix < DLY_ONE) begin
            fix = DLY_ONE;
        end
        w4 = w4 && (pfldCnt != 3'h0 || storeCnt != 3'h0 || addrCnt != 3'h0);
        w5 = storeCnt >= STORE_LIMIT && (((isMem && !isLoad) && !inst.dcHit) ||
             (isLoad && !inst.dcHit) || (inst.op == OP_FLUSH && inst.modified));
        if (w5 && fix < DLY_ONE) begin
            fix = DLY_ONE;
        end
        w6 = isMem && addrCnt >= ADDR_LIMIT;
        waitAny = w3 || w4 || w5 || w6;
        // misses add, others take the longest
        missSum = 5'((missInst ? missInstClocks : 4'h0)) +
                  5'((missData ? missDataClocks : 4'h0));
        post = (missSum > fix) ? missSum : fix;
    end

    assign hazardNow = state == ST_RUN && inst.valid && !served &&
                       (post != 5'h00 || waitAny);
    assign freeze = state != ST_RUN || hazardNow || ctrl[CTRL_HOLD];
    assign issueAccept = inst.valid && !freeze;

    // Waits end when every latched condition has cleared.
    assign evClear = (!waitPfld || pfldCnt < PFLD_LIMIT) &&
                     (!waitDrain || (pfldCnt == 3'h0 && storeCnt == 3'h0 &&
                      addrCnt == 3'h0)) &&
                     (!waitStore || readySeen || writeAck) &&
                     (!waitAddr || addrCnt < ADDR_LIMIT);

    // Transfer-ready arrives from a pin and is synchronised first.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readySync <= 2'b11;
        end else begin
            readySync <= {readySync[0], readyN};
        end
    end
    assign writeAck = !readySync[1];

    // hold while frozen
    // Freeze sequencer: wait for bus events, then count out the freeze length in post.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RUN;
            cnt <= 5'h00;
            served <= 1'b0;
            {waitPfld, waitDrain, waitStore, waitAddr} <= 4'h0;
        end else begin
            unique case (state)
                ST_RUN: begin
                    if (issueAccept) begin
                        served <= 1'b0;
                    end else if (hazardNow) begin
                        {waitPfld, waitDrain, waitStore, waitAddr} <= {w3, w4, w5, w6};
                        cnt <= post - DLY_ONE;
                        // A plain one-clock freeze ends in this very cycle.
                        if (waitAny) begin
                            state <= ST_WAIT;
                            cnt <= post;
                        end else if (post > DLY_ONE) begin
                            state <= ST_COUNT;
                        end else begin
                            served <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    // The clearing cycle itself is the first post clock.
                    if (evClear) begin
                        if (cnt > DLY_ONE) begin
                            state <= ST_COUNT;
                            cnt <= cnt - DLY_ONE;
                        end else begin
                            state <= ST_RUN;
                            served <= 1'b1;
                        end
                    end
                end
                ST_COUNT: begin
                    cnt <= cnt - DLY_ONE;
                    if (cnt == DLY_ONE) begin
                        state <= ST_RUN;
                        served <= 1'b1;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // A write beat seen while waiting is remembered until the wait ends.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readySeen <= 1'b0;
        end else if (state != ST_WAIT) begin
            readySeen <= 1'b0;
        end else if (writeAck) begin
            readySeen <= 1'b1;
        end
    end

    // Occupancy of the pipelined load, store and address pipes.
    pfi_pending uPfld (.clk(clk), .rst_n(rst_n),
        .inc(issueAccept && inst.op == OP_PFLD), .dec(pfldReturn), .count(pfldCnt));
    // Only misses occupy the store and address pipes; a cache hit never reaches the bus.
    pfi_pending uStore (.clk(clk), .rst_n(rst_n),
        .inc(issueAccept && isMem && !isLoad && !inst.dcHit),
        .dec(writeAck), .count(storeCnt));
    pfi_pending uAddr (.clk(clk), .rst_n(rst_n),
        .inc(issueAccept && isMem && !inst.dcHit), .dec(addrIssued), .count(addrCnt));

    // Stage traits and history move only when an instruction issues; the flag pulse is reloaded every clock.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stageTrait <= '0;
            prevDest <= 5'h00;
            prevFreg <= 5'h00;
            {prevGraph, prevGraphMove, prevStoreHit, prevFst} <= 4'h0;
            flagUpdate <= 1'b0;
        end else begin
            flagUpdate <= issueAccept && curTrait.setsFlag;
            if (issueAccept) begin
                stageTrait <= curTrait;
                prevDest <= inst.dest;
                prevFreg <= inst.src1;
                prevGraph <= isGraph;
                prevGraphMove <= inst.op == OP_FMOV;
                prevStoreHit <= (inst.op == OP_ST || inst.op == OP_FST) && inst.dcHit;
                prevFst <= inst.op == OP_FST;
            end
        end
    end

    // Bus slave: zero-wait access, read data captured in the setup cycle.
    assign pready = 1'b1;
    assign wrEn = psel && penable && pwrite;
    assign events = {issueAccept && curTrait.faults[FLT_INSTR], hazardNow};
    assign irq = |(irqStat & irqMask);

    // Unmapped addresses answer with an error.
    always_comb begin
        pslverr = psel && penable && !(paddr inside {ADDR_CTRL, ADDR_STATUS,
                  ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_STALLS});
    end

    // Writable registers; a new event wins over a one-to-clear write.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= RST_CTRL;
            irqMask <= RST_MASK;
            irqStat <= 2'h0;
            stalls <= 16'h0000;
        end else begin
            if (wrEn && paddr == ADDR_CTRL) begin
                ctrl <= pwdata;
            end
            if (wrEn && paddr == ADDR_IRQ_MASK) begin
                irqMask <= pwdata[1:0];
            end
            irqStat <= (irqStat & ~((wrEn && paddr == ADDR_IRQ_STAT) ?
                       pwdata[1:0] : 2'h0)) | events;
            if (wrEn && paddr == ADDR_STALLS) begin
                stalls <= 16'h0000;
            end else if (freeze && inst.valid) begin
                stalls <= stalls + 16'h0001;
            end
        end
    end

    // Read data is registered in the setup cycle of a read.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                ADDR_CTRL: prdata <= ctrl;
                ADDR_STATUS: begin
                    prdata[ST_STATE_LSB +: 2] <= state;
                    prdata[ST_PFLD_LSB +: 3] <= pfldCnt;
                    prdata[ST_STORE_LSB +: 3] <= storeCnt;
                    prdata[ST_ADDR_LSB +: 3] <= addrCnt;
                end
                ADDR_IRQ_STAT: prdata[1:0] <= irqStat;
                ADDR_IRQ_MASK: prdata[1:0] <= irqMask;
                ADDR_STALLS: prdata[15:0] <= stalls;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // A two-clock freeze: one counting clock, then back to issue.
    sequence s_twoStall;
        hazardNow && !waitAny && post == DLY_TWO && !ctrl[CTRL_HOLD];
    endsequence
    sequence s_countOut;
        state == ST_COUNT ##1 state == ST_RUN && !hazardNow;
    endsequence

    a_freeze_blocks_issue: assert property (freeze |-> !issueAccept)
        else $error("Instruction issued during a freeze.");
    a_two_clock_stall: assert property (s_twoStall |=> s_countOut)
        else $error("Two-clock freeze did not last exactly two clocks.");
    a_pfld_limit_wait: assert property (
        state == ST_WAIT && waitPfld && pfldCnt >= PFLD_LIMIT |=> state != ST_RUN)
        else $error("Pipelined load issued with the load pipe full.");
    a_store_pipe_wait: assert property (
        state == ST_WAIT && waitStore && !readySeen && !writeAck |=> state == ST_WAIT)
        else $error("Store-pipe freeze ended before a write ready.");
    a_addr_pipe_hold: assert property (
        inst.valid && isMem && addrCnt >= ADDR_LIMIT && !served |-> !issueAccept)
        else $error("Memory access issued with the address pipe full.");
    a_load_after_hit: assert property (
        state == ST_RUN && inst.valid && !served && prevStoreHit &&
        (inst.op == OP_LD || inst.op == OP_FLD) |-> hazardNow && post >= DLY_ONE)
        else $error("Load after a store hit was not frozen.");
    a_graph_forward: assert property (
        state == ST_RUN && inst.valid && !served && prevGraph && isGraph && srcMatch
        |-> hazardNow)
        else $error("Graphics result forwarding was not frozen.");
    a_store_overwrite: assert property (
        state == ST_RUN && inst.valid && !served && prevFst && isPipeFp &&
        inst.dest == prevFreg |-> hazardNow)
        else $error("Store followed by overwrite was not frozen.");
    a_miss_sum: assert property (
        hazardNow |-> post >= missSum && post >= fix)
        else $error("Freeze shorter than the summed miss delays.");
    a_flag_update: assert property (
        issueAccept && inst.op == OP_SHIFT |=> !flagUpdate)
        else $error("Shift updated the condition flag.");
    a_delay_slot: assert property (
        issueAccept && inst.op == OP_BR |=> stageTrait.delayed && !stageTrait.setsFlag)
        else $error("Direct branch not marked as delayed.");
endmodule
`default_nettype wire

// ### pfi_bus_model.sv
// Behavioural external memory bus answering the interlock's issued loads and stores.
`timescale 1ns/1ps
`default_nettype none
module pfi_bus_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire pfi_pkg::pfi_inst_t inst,
    input wire logic issueAccept,
    output logic pfldReturn,
    output logic addrIssued,
    output logic readyN
);
    import pfi_pkg::*;
    logic [2:0] ret; // Age line of issued pipelined loads.
    logic [2:0] miss; // Age line of issued missing loads and stores.
    wire logic acc = inst.valid && issueAccept;
    // Returns load data three clocks late; a miss gets its address out, then one ready beat.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ret <= '0;
            miss <= '0;
        end else begin
            ret <= {ret[1:0], acc && inst.op == OP_PFLD};
            miss <= {miss[1:0], acc && !inst.dcHit &&
                     inst.op inside {OP_LD, OP_ST, OP_FLD, OP_FST, OP_PFLD}};
        end
    end
    assign pfldReturn = ret[2];
    assign addrIssued = miss[0];
    assign readyN = ~miss[2];
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench of the pipeline freeze interlock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pfi_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er, mi = 0, md = 0;
    logic pready, pslverr, issueAccept, freeze, flagUpdate, irq, pfldReturn, addrIssued, readyN;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    pfi_inst_t inst = '0;
    pfi_trait_t stageTrait;
    int mismatches = 0, compares = 0, n, m, s;
    always #25 clk = ~clk;
    pfi_interlock u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .inst(inst), .pfldReturn(pfldReturn), .addrIssued(addrIssued),
        .readyN(readyN), .missInst(mi), .missInstClocks(4'h3), .missData(md),
        .missDataClocks(4'h2), .issueAccept(issueAccept), .freeze(freeze),
        .stageTrait(stageTrait), .flagUpdate(flagUpdate), .irq(irq));
    pfi_bus_model u_bus (.clk(clk), .rst_n(rst_n), .inst(inst), .issueAccept(issueAccept),
        .pfldReturn(pfldReturn), .addrIssued(addrIssued), .readyN(readyN));
    task automatic end_of_test;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("Error %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One APB transfer; waits for pready under a bound.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
        rd = prdata; er = pslverr;
        if (k >= 20) begin mismatches++; end_of_test(); end
        psel <= 0; penable <= 0;
    endtask
    // Offers one instruction, counts frozen cycles, ends at the accepting edge.
    task automatic issue(input pfi_op_t op, input logic [4:0] d, s1, input logic tk, h,
        output int c);
        c = 0;
        inst <= '{1'b1, op, d, s1, 5'h00, tk, h, 1'b0};
        @(negedge clk);
        while (issueAccept !== 1'b1) begin
            c++;
            if (c > 40) begin mismatches++; end_of_test(); end
            @(negedge clk);
        end
        @(posedge clk);
    endtask
    task automatic idle;
        inst.valid <= 0;
        repeat (3) @(posedge clk);
    endtask
    // Producer then consumer of register r; total stall in t.
    task automatic pair(input pfi_op_t a, b, input logic [4:0] r, input logic tk, output int t);
        issue(a, r, 5'h1F, tk, 1, n);
        issue(b, 5'h1E, r, 0, 1, m);
        idle();
        t = n + m;
    endtask
    task automatic t_regs;
        apb(0, ADDR_CTRL, 0); chk(rd, RST_CTRL);
        apb(0, ADDR_IRQ_MASK, 0); chk(rd, {30'h0, RST_MASK});
        apb(0, ADDR_STATUS, 0); chk(rd, 32'h0);
        apb(0, 8'h20, 0); chk(rd, 32'h0); chk(32'(er), 1);
        apb(1, ADDR_CTRL, 32'h1);
        inst <= '{1'b1, OP_SHIFT, 5'h01, 5'h02, 5'h00, 1'b0, 1'b1, 1'b0};
        repeat (4) begin @(negedge clk); chk(32'(freeze), 1); end
        apb(1, ADDR_CTRL, 32'h0);
        idle();
    endtask
    task automatic t_hazards;
        issue(OP_ST, 5'h00, 5'h02, 0, 1, n); issue(OP_LD, 5'h03, 5'h04, 0, 1, m); idle();
        chk(32'(n + m), 1);
        issue(OP_PFLD, 5'h08, 5'h00, 0, 1, n); idle(); chk(32'(n), 2);
        issue(OP_FST, 5'h00, 5'h07, 0, 1, n); issue(OP_PFADD, 5'h07, 5'h01, 0, 1, m); idle();
        chk(32'(n + m), 1);
        mi <= 1; md <= 1; issue(OP_ADDSUB, 5'h01, 5'h02, 0, 1, n); mi <= 0; md <= 0; idle();
        chk(32'(n), 5);
        issue(OP_LD, 5'h03, 5'h04, 0, 0, n); issue(OP_LD, 5'h05, 5'h04, 0, 1, m); idle();
        chk(32'(m != 0), 1);
        pair(OP_GRAPH, OP_FADD, 5'h06, 0, s); chk(32'(s), 1);
        pair(OP_FMOV, OP_FADD, 5'h06, 0, s); chk(32'(s), 0);
        pair(OP_PGRAPH, OP_GRAPH, 5'h06, 0, s); chk(32'(s), 1);
    endtask
    task automatic t_branch;
        pair(OP_BCT, OP_ADDSUB, 5'h05, 0, s); chk(32'(s), 1);
        pair(OP_BC, OP_ADDSUB, 5'h05, 1, s); chk(32'(s), 1);
        pair(OP_BCT, OP_ADDSUB, 5'h05, 1, s); chk(32'(s), 0);
        pair(OP_BC, OP_ADDSUB, 5'h05, 0, s); chk(32'(s), 0);
    endtask
    // Whole trait record per class followed by the flag pulse.
    // delay slots hold plain instructions.
    task automatic t_traits;
        pfi_op_t ops[9] = '{OP_BR, OP_ADDSUB, OP_BCT, OP_SHIFT, OP_BC, OP_TRAP, OP_LD, OP_PFCMP,
            OP_PFMUL};
        logic [11:0] ex[9] = '{12'h0A0, 12'h061, 12'h0A0, 12'h020, 12'h020, 12'h022, 12'h030,
            12'h365, 12'h52C};
        for (int i = 0; i < 9; i++) begin
            issue(ops[i], 5'h10, 5'h00, 1, 1, n);
            inst.valid <= 0;
            @(negedge clk);
            chk({20'h0, stageTrait, flagUpdate}, {20'h0, ex[i]});
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic t_irq;
        apb(0, ADDR_IRQ_STAT, 0); chk(rd, 32'h3);
        @(negedge clk); chk(32'(irq), 0);
        apb(1, ADDR_IRQ_MASK, 32'h1); @(negedge clk); chk(32'(irq), 1);
        apb(1, ADDR_IRQ_STAT, 32'h3); @(negedge clk); chk(32'(irq), 0);
        apb(0, ADDR_IRQ_STAT, 0); chk(rd, 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_regs();
        t_hazards();
        t_branch();
        t_traits();
        t_irq();
        end_of_test();
    end
endmodule
`default_nettype wire
